// >>> design/ecs_defines.vh
// constants and behaviour notes for the encoder counter status block
// Notes on behaviour
// [R1] bit 0 high while target compare runs
// [R2] bit 0 stays low during range compare
// [R3] target compare runs until match, counter stop or range mode once begun
// [R4] linear mode: bit 1 flags overflow/underflow
// [R5] circular mode never sets bit 1
// [R6] linear overflow freezes count at the limit
// [R7] bit 1 cleared only by counter stop (the code also reads bit 1 as low while circular mode is set)
// [R8] phase z plus soft reset: bit 3 pulses
// [R9] reset only on z rise with reset bit
// [R10] bit 4 set on rotation read failure
// [R11] bit 5 set when rotation read finishes
// [R12] absolute modes capture signed 32-bit rotations
// [R13] pulses and flags update at refresh tick
`ifndef ECS_DEFINES_VH
`define ECS_DEFINES_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ECS_OFF_STATUS 8'h00
`define ECS_OFF_CTRL 8'h04
`define ECS_OFF_IRQ_STAT 8'h08
`define ECS_OFF_IRQ_MASK 8'h0C
`define ECS_OFF_COUNT 8'h10
`define ECS_OFF_ROT 8'h14
`define ECS_OFF_CMP 8'h18
`define ECS_OFF_PRESET 8'h1C
// ------------------------------------------------------------
// status word bit positions
// ------------------------------------------------------------
`define ECS_ST_TGT 0
`define ECS_ST_OVF 1
`define ECS_ST_ZRST 3
`define ECS_ST_RDERR 4
`define ECS_ST_RDDONE 5
// ------------------------------------------------------------
// control bit positions
// ------------------------------------------------------------
`define ECS_CT_START 0
`define ECS_CT_RESET 1
`define ECS_CT_CIRC 2
`define ECS_CT_ABS 3
`define ECS_CT_ZSOFT 4
`define ECS_CT_TGT 5
`define ECS_CT_RANGE 6
`define ECS_CT_SENSE 7
`define ECS_CT_PRESET 8
// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define ECS_CTRL_RST 16'h0000
`define ECS_CLK_MHZ 125
`define ECS_REFRESH_US 1
`define ECS_REFRESH_CYC (`ECS_REFRESH_US * `ECS_CLK_MHZ)
`define ECS_ROT_TIMEOUT_US 20
`define ECS_ROT_TIMEOUT_CYC (`ECS_ROT_TIMEOUT_US * `ECS_CLK_MHZ)
`endif

// >>> design/ecs_rot_reader.v
// serial receiver for the absolute rotation count
`timescale 1ns/100ps
`include "ecs_defines.vh"
module ecs_rot_reader #(
	parameter TIMEOUT = `ECS_ROT_TIMEOUT_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire start,
	input wire ser_clk_en,
	input wire ser_data,
	output reg busy,
	output reg done,
	output reg err,
	output reg [31:0] value
);
	reg [31:0] shift_reg;
	reg [5:0] bits_reg;
	reg [15:0] tmo_reg;
	// ------------------------------------------------------------
	// shift 32 bits msb first, abort on timeout
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		done <= 1'b0;
		err <= 1'b0;
		if (!aresetn) begin
			busy <= 1'b0;
			value <= 32'h00000000;
			shift_reg <= 32'h00000000;
			bits_reg <= 6'h00;
			tmo_reg <= 16'h0000;
		end else if (start && !busy) begin
			busy <= 1'b1;
			bits_reg <= 6'h00;
			tmo_reg <= 16'h0000;
		end else if (busy) begin
			tmo_reg <= tmo_reg + 16'h0001;
			if (ser_clk_en) begin
				shift_reg <= {shift_reg[30:0], ser_data};
				bits_reg <= bits_reg + 6'h01;
				tmo_reg <= 16'h0000; // a bit restarts the silence timer
				if (bits_reg == 6'h1F) begin
					busy <= 1'b0;
					done <= 1'b1;
					value <= {shift_reg[30:0], ser_data}; // R12
				end
			end else if (tmo_reg == TIMEOUT[15:0]) begin
				busy <= 1'b0;
				err <= 1'b1;
			end
		end
	end
endmodule

// >>> design/ecs_top.v
// encoder counter 1 status flags with axi4-lite registers
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "ecs_defines.vh"
module ecs_top #(
	parameter REFRESH = `ECS_REFRESH_CYC,
	parameter ROT_TIMEOUT = `ECS_ROT_TIMEOUT_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire enc_up,
	input wire enc_down,
	input wire phase_z,
	input wire ser_clk_en,
	input wire ser_data,
	output reg servo_sense_request,
	output wire irq
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	reg [15:0] ctrl_reg;
	reg [31:0] cmp_reg;
	reg [31:0] preset_reg;
	reg [31:0] present_count;
	reg [31:0] rot_reg;
	reg [15:0] status_reg;
	reg [15:0] irq_stat_reg;
	reg [15:0] irq_mask_reg;
	reg tgt_run_reg;
	reg ovf_reg;
	reg z_prev_reg;
	reg z_pend_reg;
	reg rd_err_reg;
	reg rd_done_reg;
	reg [15:0] tick_reg;
	reg aw_got_reg;
	reg w_got_reg;
	reg [7:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	wire tick;
	wire rd_busy;
	wire rd_done;
	wire rd_err;
	wire [31:0] rd_value;
	wire wr_fire;
	wire [15:0] new_status;
	wire [15:0] events;
	reg [31:0] ctrl_wr;
	reg rd_start;
	reg [31:0] mask_wr;
	reg [31:0] clr_wr;
	reg [15:0] irq_clr;
	reg tgt_go;

	// merge byte lanes of a write into an old value
	function [31:0] merge;
		input [31:0] old;
		input [31:0] dat;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = dat[i*8 +: 8];
				end
			end
		end
	endfunction

	// ------------------------------------------------------------
	// write channel: address and data taken in either order
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
	assign wr_fire = aw_got_reg && w_got_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_reg)
				`ECS_OFF_CTRL, `ECS_OFF_IRQ_STAT, `ECS_OFF_IRQ_MASK,
				`ECS_OFF_CMP, `ECS_OFF_PRESET: s_axi_bresp <= 2'h0;
				default: s_axi_bresp <= 2'h2; // slverr, unmapped or ro
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	always @* begin
		ctrl_wr = merge({16'h0000, ctrl_reg}, w_data_reg, w_strb_reg);
		mask_wr = merge({16'h0000, irq_mask_reg}, w_data_reg, w_strb_reg);
		clr_wr = merge(32'h00000000, w_data_reg, w_strb_reg);
		irq_clr = 16'h0000;
		if (wr_fire && aw_addr_reg == `ECS_OFF_IRQ_STAT) begin
			irq_clr = clr_wr[15:0];
		end
		// a control write with start and target set, range clear, begins target compare once
		tgt_go = wr_fire && aw_addr_reg == `ECS_OFF_CTRL
			&& ctrl_wr[`ECS_CT_TGT] && ctrl_wr[`ECS_CT_START]
			&& !ctrl_wr[`ECS_CT_RANGE];
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `ECS_CTRL_RST;
			cmp_reg <= 32'h00000000;
			preset_reg <= 32'h00000000;
			irq_mask_reg <= 16'h0000;
		end else if (wr_fire) begin
			case (aw_addr_reg)
			`ECS_OFF_CTRL: ctrl_reg <= ctrl_wr[15:0];
			`ECS_OFF_CMP: cmp_reg <= merge(cmp_reg, w_data_reg, w_strb_reg);
			`ECS_OFF_PRESET:
				preset_reg <= merge(preset_reg, w_data_reg, w_strb_reg);
			`ECS_OFF_IRQ_MASK: irq_mask_reg <= mask_wr[15:0];
			default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
			`ECS_OFF_STATUS: s_axi_rdata <= {16'h0000, status_reg};
			`ECS_OFF_CTRL: s_axi_rdata <= {16'h0000, ctrl_reg};
			`ECS_OFF_IRQ_STAT: s_axi_rdata <= {16'h0000, irq_stat_reg};
			`ECS_OFF_IRQ_MASK: s_axi_rdata <= {16'h0000, irq_mask_reg};
			`ECS_OFF_COUNT: s_axi_rdata <= present_count;
			`ECS_OFF_ROT: s_axi_rdata <= rot_reg;
			`ECS_OFF_CMP: s_axi_rdata <= cmp_reg;
			`ECS_OFF_PRESET: s_axi_rdata <= preset_reg;
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// refresh tick
	// ------------------------------------------------------------
	assign tick = (tick_reg == REFRESH[15:0] - 16'h0001);

	always @(posedge aclk) begin
		if (!aresetn || tick) begin
			tick_reg <= 16'h0000;
		end else begin
			tick_reg <= tick_reg + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// counter core with linear clamp and phase z reset
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			present_count <= 32'h00000000;
			ovf_reg <= 1'b0;
			z_prev_reg <= 1'b0;
			z_pend_reg <= 1'b0;
		end else begin
			z_prev_reg <= phase_z;
			if (tick) begin
				z_pend_reg <= 1'b0;
			end
			if (!ctrl_reg[`ECS_CT_START]) begin
				ovf_reg <= 1'b0; // R7
			end else if (phase_z && !z_prev_reg && ctrl_reg[`ECS_CT_RESET]
				&& ctrl_reg[`ECS_CT_ZSOFT]) begin
				present_count <= 32'h00000000; // R9
				z_pend_reg <= 1'b1; // R8
			end else if (ctrl_reg[`ECS_CT_ABS] && rd_done) begin
				present_count <= rd_value; // R12
			end else if (enc_up && !enc_down) begin
				if (present_count == 32'h7FFFFFFF && !ctrl_reg[`ECS_CT_CIRC]) begin
					ovf_reg <= 1'b1; // R4 R6
				end else if (!ovf_reg || ctrl_reg[`ECS_CT_CIRC]) begin
					present_count <= present_count + 32'h00000001; // R5
				end
			end else if (enc_down && !enc_up) begin
				if (present_count == 32'h80000000 && !ctrl_reg[`ECS_CT_CIRC]) begin
					ovf_reg <= 1'b1; // R4 R6
				end else if (!ovf_reg || ctrl_reg[`ECS_CT_CIRC]) begin
					present_count <= present_count - 32'h00000001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// target comparison runs until match, start off or range mode
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			tgt_run_reg <= 1'b0;
		end else if (tgt_go) begin
			tgt_run_reg <= 1'b1; // R1
		end else if (!ctrl_reg[`ECS_CT_START] || ctrl_reg[`ECS_CT_RANGE]) begin
			tgt_run_reg <= 1'b0; // R2
		end else if (tgt_run_reg && present_count == cmp_reg) begin
			tgt_run_reg <= 1'b0;
		end // R3: nothing else stops it
	end

	// ------------------------------------------------------------
	// absolute rotation read, started by sense request
	// ------------------------------------------------------------
	always @* begin
		rd_start = ctrl_reg[`ECS_CT_SENSE] && ctrl_reg[`ECS_CT_ABS]
			&& !servo_sense_request;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			servo_sense_request <= 1'b0;
			rd_err_reg <= 1'b0;
			rd_done_reg <= 1'b0;
			rot_reg <= 32'h00000000;
		end else begin
			servo_sense_request <= ctrl_reg[`ECS_CT_SENSE];
			if (rd_start) begin
				rd_err_reg <= 1'b0;
				rd_done_reg <= 1'b0; // R11
			end
			if (rd_err) begin
				rd_err_reg <= 1'b1; // R10
			end
			if (rd_done) begin
				rd_done_reg <= 1'b1; // R11
				rot_reg <= rd_value; // R12
			end
		end
	end

	ecs_rot_reader #(.TIMEOUT(ROT_TIMEOUT)) u_rot (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(rd_start),
		.ser_clk_en(ser_clk_en),
		.ser_data(ser_data),
		.busy(rd_busy),
		.done(rd_done),
		.err(rd_err),
		.value(rd_value)
	);

	// ------------------------------------------------------------
	// status word sampled at each refresh
	// ------------------------------------------------------------
	assign new_status = {10'h000, rd_done_reg && !rd_busy, rd_err_reg,
		z_pend_reg || (status_reg[`ECS_ST_ZRST] && 1'b0), 1'b0,
		ovf_reg && !ctrl_reg[`ECS_CT_CIRC], tgt_run_reg};
	assign events = new_status & ~status_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= 16'h0000;
		end else if (tick) begin
			status_reg <= new_status; // R13
		end
	end

	// ------------------------------------------------------------
	// interrupt: sticky rising edges, write one to clear
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= 16'h0000;
		end else begin
			// an event at the tick beats a clear in the same cycle
			irq_stat_reg <= (irq_stat_reg & ~irq_clr)
				| (tick ? events : 16'h0000);
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule

// >>> verif/ecs_chk.sv
// assertion checker for the encoder counter status block
`timescale 1ns/100ps
module ecs_chk #(
	parameter REFRESH = 4
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire servo_sense_request
);
	logic [7:0] ctrl_q;
	logic [7:0] ra_q;
	logic [9:0] age;
	wire st_rd = s_axi_rvalid && ra_q == 8'h00;
	wire settled = age > 3 * REFRESH;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// shadow of the control byte and cycles since it was written
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= 8'h00;
			age <= 10'h000;
		end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
			s_axi_wready && s_axi_awaddr == 8'h04 && s_axi_wstrb[0]) begin
			ctrl_q <= s_axi_wdata[7:0];
			age <= 10'h000;
		end else if (age != 10'h3FF) begin
			age <= age + 10'h001;
		end
	end
	// address of the read under way
	always @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			ra_q <= s_axi_araddr;
		end
	end
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_bad_read: assert property (s_axi_rvalid && ra_q > 8'h1F
		|-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_circ_no_ovf: assert property (st_rd && ctrl_q[2]
		|-> !s_axi_rdata[1]) else $error("overflow in circular mode");
	a_range_no_tgt: assert property (st_rd && settled && ctrl_q[6]
		|-> !s_axi_rdata[0]) else $error("target flag in range mode");
	a_stop_clears: assert property (st_rd && settled && !ctrl_q[0]
		|-> s_axi_rdata[1:0] == 2'b00) else $error("flags after stop");
	a_sense_copy: assert property (age > 10'h002
		|-> servo_sense_request == ctrl_q[7]) else $error("sense stale");
endmodule
bind ecs_top ecs_chk #(.REFRESH(REFRESH)) u_chk (.aclk, .aresetn,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .servo_sense_request);

// >>> verif/ecs_enc_model.sv
// encoder and servo driver model: phase z and serial rotation count
`timescale 1ns/100ps
module ecs_enc_model (
	input wire aclk,
	input wire servo_sense_request,
	input wire z_go,
	input wire mute,
	input wire [31:0] rot,
	output logic phase_z,
	output logic ser_clk_en,
	output logic ser_data
);
	logic sense_d = 1'b0;
	initial begin
		phase_z = 1'b0;
		ser_clk_en = 1'b0;
		ser_data = 1'b0;
	end
	// three-cycle phase z pulse on request
	always @(posedge z_go) begin
		@(posedge aclk);
		phase_z <= 1'b1;
		repeat (3) @(posedge aclk);
		phase_z <= 1'b0;
	end
	always @(posedge aclk) sense_d <= servo_sense_request;
	// msb first; the line shows the inverse between bits
	always @(posedge aclk) begin
		if (servo_sense_request && !sense_d && !mute) begin
			repeat (4) @(posedge aclk);
			for (int i = 31; i >= 0; i--) begin
				ser_data <= rot[i];
				ser_clk_en <= 1'b1;
				@(posedge aclk);
				ser_clk_en <= 1'b0;
				ser_data <= ~rot[i];
				@(posedge aclk);
			end
		end
	end
endmodule

// >>> verif/test_encoder_counter_status_flags.sv
// self-checking bench for the encoder counter status block
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
	fail_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module test_encoder_counter_status_flags;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, enc_up = 1'b0;
	logic z_go = 1'b0, mute = 1'b0, enc_down = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, rdat;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] resp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, phase_z, ser_clk_en, ser_data, servo_sense_request;
	wire irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int fail_count = 0, cmp_count = 0, cyc = 0;
	localparam [31:0] ROTV = 32'h80000001;
	ecs_top #(.REFRESH(4), .ROT_TIMEOUT(64)) dut (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .enc_up, .enc_down, .phase_z, .ser_clk_en,
		.ser_data, .servo_sense_request, .irq);
	ecs_enc_model enc (.aclk, .servo_sense_request, .z_go, .mute,
		.rot(ROTV), .phase_z, .ser_clk_en, .ser_data);
	// bus write: address and data released each when taken
	task automatic wr(input [7:0] a, input [31:0] d);
		bit ad, wd, ah, wh, b;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		{ad, wd, b} = 3'b000;
		while (!b) begin
			#1;
			ah = !ad && s_axi_awready;
			wh = !wd && s_axi_wready;
			b = ad && wd && s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
			ad |= ah;
			wd |= wh;
		end
	endtask
	// bus read, then masked compare
	task automatic rdc(input [7:0] a, input [31:0] m, e, input string n);
		bit ah, r;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r = 1'b0;
		while (!r) begin
			#1;
			ah = s_axi_arvalid && s_axi_arready;
			r = !s_axi_arvalid && s_axi_rvalid;
			{rdat, resp} = {s_axi_rdata, s_axi_rresp};
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
		end
		`CHK(n, e, rdat & m)
	endtask
	task automatic zpulse;
		z_go <= 1'b1;
		@(posedge aclk);
		z_go <= 1'b0;
		repeat (20) @(posedge aclk);
		#1;
	endtask
	// reset values, refused accesses, circular mode
	task automatic t_regs;
		rdc(8'h04, 32'hFFFFFFFF, 32'h0, "ctrl");
		rdc(8'h0C, 32'hFFFFFFFF, 32'h0, "mask");
		rdc(8'h00, 32'hFFFFFFFF, 32'h0, "status");
		rdc(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
		`CHK("rresp", 2'b10, resp)
		wr(8'h00, 32'h3F);
		`CHK("bresp", 2'b10, resp)
		wr(8'h44, 32'h1);
		`CHK("bresp", 2'b10, resp)
		wr(8'h04, 32'h45);
		repeat (16) @(posedge aclk);
		rdc(8'h00, 32'h3, 32'h0, "status");
	endtask
	// target compare runs until the count meets the target
	task automatic t_target;
		wr(8'h04, 32'h0);
		wr(8'h18, 32'hC8);
		wr(8'h04, 32'h21);
		enc_up <= 1'b1;
		repeat (12) @(posedge aclk);
		rdc(8'h00, 32'h1, 32'h1, "target");
		repeat (40) @(posedge aclk);
		rdc(8'h00, 32'h1, 32'h1, "target");
		wr(8'h04, 32'h61);
		repeat (16) @(posedge aclk);
		rdc(8'h00, 32'h1, 32'h0, "target");
		wr(8'h04, 32'h21);
		repeat (200) @(posedge aclk);
		rdc(8'h00, 32'h1, 32'h0, "target");
		enc_up <= 1'b0;
		wr(8'h04, 32'h0);
	endtask
	// phase z resets the count only with the reset bit held
	task automatic t_zero;
		wr(8'h08, 32'h3F);
		wr(8'h0C, 32'h08);
		wr(8'h04, 32'h13);
		zpulse;
		`CHK("irq", 1'b1, irq)
		rdc(8'h08, 32'h08, 32'h08, "irq status");
		rdc(8'h10, 32'hFFFFFFFF, 32'h0, "count");
		wr(8'h08, 32'h08);
		#1;
		`CHK("irq", 1'b0, irq)
		wr(8'h04, 32'h11);
		enc_up <= 1'b1;
		repeat (10) @(posedge aclk);
		enc_up <= 1'b0;
		zpulse;
		rdc(8'h08, 32'h08, 32'h0, "irq status");
		rdc(8'h10, 32'hFFFFFFFF, 32'hA, "count");
		wr(8'h04, 32'h0);
	endtask
	// rotation read completes, then fails with a silent encoder
	task automatic t_rot;
		wr(8'h04, 32'h08);
		wr(8'h04, 32'h88);
		rdc(8'h00, 32'h30, 32'h0, "read flags");
		repeat (100) @(posedge aclk);
		rdc(8'h00, 32'h30, 32'h20, "read flags");
		rdc(8'h14, 32'hFFFFFFFF, ROTV, "rotations");
		mute <= 1'b1;
		wr(8'h04, 32'h08);
		wr(8'h04, 32'h88);
		repeat (120) @(posedge aclk);
		rdc(8'h00, 32'h30, 32'h10, "read flags");
	endtask
	// linear limit freezes and flags, stop clears, circular wraps
	task automatic t_limit;
		mute <= 1'b0;
		wr(8'h04, 32'h08);
		wr(8'h04, 32'h89);
		repeat (100) @(posedge aclk);
		rdc(8'h10, 32'hFFFFFFFF, ROTV, "count");
		enc_down <= 1'b1;
		repeat (8) @(posedge aclk);
		enc_down <= 1'b0;
		rdc(8'h00, 32'h2, 32'h2, "overflow");
		rdc(8'h10, 32'hFFFFFFFF, 32'h80000000, "count");
		wr(8'h04, 32'h08);
		repeat (8) @(posedge aclk);
		rdc(8'h00, 32'h2, 32'h0, "overflow");
		wr(8'h04, 32'h05);
		enc_down <= 1'b1;
		@(posedge aclk);
		enc_down <= 1'b0;
		repeat (8) @(posedge aclk);
		rdc(8'h00, 32'h2, 32'h0, "overflow");
		rdc(8'h10, 32'hFFFFFFFF, 32'h7FFFFFFF, "count");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		forever #4 aclk = ~aclk;
	end
	// hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			test_done;
		end
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_target;
		t_zero;
		t_rot;
		t_limit;
		test_done;
	end
endmodule
